// ---- core/touch_panel_scan_control.sv ----
// Overview of operation
// - Control bits 15 and 14 always read as zero.
// - Control bit 13 shows captured contact state, one touch, zero release.
// - Sequencer state readable as three-bit code; 011 never appears.
// - Two pages of five halfword coordinate buffers, readable and writable.
// - Four halfword port-scan buffers, readable and writable.
// - Sample period counter is read-only; writes change nothing.
// - Pending register shows which unit interrupt causes are set.
// - Mask register selects which causes reach the processor.
// - Writable sampling interval spaces successive coordinate sets.
// - Writable delay between converter activation and conversion start.
// - Soft reset bit self-clears after four touch ticks; sequencer goes disabled.
// - Captured contact frozen while pen-change flag set, live when clear.
// - Release in interval: auto-stop goes waiting, else rescan after interval.
// - Mode 00 coordinate sampling, 01 command conversion, 10/11 reserved.
`timescale 1ns/1ps
module touch_panel_scan_control
	import touch_panel_pkg::*;
#(
	parameter int TOUCH_DIV = TOUCH_DIV_DEFAULT
)(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Panel contact pin, high while touched
	input  wire logic        pen_contact,
	// A/D converter, same clock
	output adc_req_t         adc_req,
	input  wire logic        adc_done,
	input  wire logic [9:0]  adc_data,
	// Interrupt
	output logic             irq
);

	typedef struct packed {
		seq_t        seq;
		logic [9:0]  ctl;
		logic        contact;
		logic        sync1;
		logic        sync2;
		logic        live;
		logic [2:0]  rst_cnt;
		logic [15:0] irq;
		logic [15:0] mask;
		logic [15:0] interval;
		logic [15:0] delay;
		logic [15:0] command;
		logic [15:0] pscan_ctl;
		logic [15:0] pscan_mask;
		logic [15:0] period;
		logic [15:0] wait_cnt;
		logic        busy;
		logic [2:0]  conv;
		logic        page;
		logic        res_pend;
		logic [3:0]  res_addr;
		logic [15:0] res;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        irq_out;
		adc_req_t    adc;
	} st_t;

	st_t         q;
	st_t         d;
	logic        tick;
	logic        mem_we;
	logic [3:0]  mem_waddr;
	logic [15:0] mem_wdata;
	logic [15:0] mem_rdata;
	logic [4:0]  slot;
	logic        xfer;
	logic        change;
	logic        done;
	logic        bus_buf;
	logic        hit;
	logic [15:0] rdata;
	logic [15:0] set;
	logic [15:0] clr;
	logic [2:0]  last;
	logic [3:0]  chan;
	logic [3:0]  dst;
	logic [9:0]  wnew;
	logic [9:0]  rise;
	logic [9:0]  fall;

	// Hit flag in bit 4, buffer slot below
	function automatic logic [4:0] buf_slot(logic [31:0] addr);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < BUF_WORDS; i++)
			if (addr[31:2] == BUF_IDX[i][29:0])
				r = {1'b1, 4'(i)};
		return r;
	endfunction

	function automatic logic [2:0] state_code(seq_t s);
		logic [2:0] c;
		c = STC_DISABLE;
		unique case (s)
			st_disable:  c = STC_DISABLE;
			st_standby:  c = STC_STANDBY;
			st_port:     c = STC_PORT;
			st_wait:     c = STC_WAIT;
			st_coord:    c = STC_COORD;
			st_interval: c = STC_INTERVAL;
			st_cmd:      c = STC_CMD;
		endcase
		return c;
	endfunction

	touch_tick_gen #(.DIV(TOUCH_DIV)) u_tick (
		.clk  (clk),
		.rstn (rstn),
		.tick (tick)
	);

	sample_buffer_mem #(.WIDTH(16), .DEPTH(BUF_WORDS)) u_mem (
		.clk   (clk),
		.we    (mem_we),
		.waddr (mem_waddr),
		.wdata (mem_wdata),
		.raddr (slot[3:0]),
		.rdata (mem_rdata)
	);

	always_comb
	begin
		d = q;
		set = 16'h0000;
		clr = 16'h0000;
		done = 1'b0;
		d.sync1 = pen_contact;
		d.sync2 = q.sync1;
		d.live = q.sync2;
		d.adc.start = 1'b0;
		change = (q.sync2 != q.live) && (q.seq != st_disable);
		if (change)
			set[IRQ_PEN] = 1'b1;

		// Bus side of the buffer write port; a pending conversion result waits one cycle
		slot = buf_slot(paddr);
		xfer = psel && penable && q.pready;
		bus_buf = xfer && pwrite && slot[4];
		mem_we = bus_buf || q.res_pend;
		mem_waddr = bus_buf ? slot[3:0] : q.res_addr;
		mem_wdata = bus_buf ? pwdata[15:0] : q.res;
		d.res_pend = q.res_pend && bus_buf;

		// Conversion engine shared by coordinate, port and command scans
		last = 3'h0;
		chan = q.command[3:0];
		dst = 4'(PORT_BASE);
		unique case (q.seq)
			st_coord:
			begin
				last = q.ctl[CTL_PRESSURE] ? 3'h4 : 3'h3;
				chan = {1'b0, q.conv};
				dst = q.page ? 4'(BUFS_PER_PAGE) + {1'b0, q.conv} : {1'b0, q.conv};
			end
			st_port:
			begin
				last = 3'h3;
				chan = PORT_CHAN_BASE + {1'b0, q.conv};
				dst = 4'(PORT_BASE) + {1'b0, q.conv};
			end
			st_disable, st_standby, st_wait, st_interval, st_cmd: ;
		endcase
		if (!(q.seq inside {st_coord, st_port, st_cmd}))
		begin
			d.busy = 1'b0;
			d.conv = 3'h0;
			d.wait_cnt = 16'h0000;
		end
		else if (!q.busy)
		begin
			if (q.wait_cnt >= q.delay)
			begin
				d.adc.start = 1'b1;
				d.adc.channel = chan;
				d.busy = 1'b1;
				d.wait_cnt = 16'h0000;
			end
			else if (tick)
				d.wait_cnt = q.wait_cnt + 16'h0001;
		end
		else if (adc_done)
		begin
			d.busy = 1'b0;
			d.res = {6'h00, adc_data};
			d.res_addr = dst;
			d.res_pend = 1'b1;
			d.conv = q.conv + 3'h1;
			done = (q.conv == last);
		end

		// Period counter runs only while sampling coordinates
		if (q.seq inside {st_coord, st_interval})
		begin
			if (tick)
				d.period = q.period + 16'h0001;
		end
		else
			d.period = 16'h0000;

		unique case (q.seq)
			st_wait:
				if (change && q.sync2 && q.ctl[CTL_AUTO_START])
					d.seq = st_coord;
			st_coord:
			begin
				// A set still running when the next period is due loses data
				if (tick && q.interval != 16'h0000 && q.period >= q.interval)
					set[IRQ_LOST] = 1'b1;
				if (done)
				begin
					set[IRQ_COORD] = 1'b1;
					d.page = ~q.page;
					d.seq = q.ctl[CTL_SCAN_STOP] ? st_standby : st_interval;
				end
			end
			st_interval:
				if (change && !q.sync2 && q.ctl[CTL_AUTO_STOP])
					d.seq = st_wait;
				else if (q.period >= q.interval)
				begin
					d.seq = st_coord;
					d.period = 16'h0000;
				end
			st_port:
				if (done)
				begin
					set[IRQ_PORT] = 1'b1;
					d.pscan_ctl[PSCAN_START] = 1'b0;
					d.seq = st_standby;
				end
			st_cmd:
				if (done)
				begin
					set[IRQ_CMD] = 1'b1;
					d.seq = st_standby;
				end
			st_disable, st_standby: ;
		endcase

		// Read data settles in the first access cycle, answered in the second
		hit = 1'b1;
		case (paddr[31:2])
			IDX_CONTROL[29:0]:     rdata = {2'b00, q.contact, state_code(q.seq), q.ctl};
			IDX_IRQ_PENDING[29:0]: rdata = q.irq;
			IDX_IRQ_CAUSE[29:0]:   rdata = q.irq;
			IDX_IRQ_MASK[29:0]:    rdata = q.mask;
			IDX_INTERVAL[29:0]:    rdata = q.interval;
			IDX_START_DELAY[29:0]: rdata = q.delay;
			IDX_ADC_COMMAND[29:0]: rdata = q.command;
			IDX_PSCAN_CTL[29:0]:   rdata = q.pscan_ctl;
			IDX_PSCAN_MASK[29:0]:  rdata = q.pscan_mask;
			IDX_PERIOD[29:0]:      rdata = q.period;
			default:
			begin
				rdata = slot[4] ? mem_rdata : 16'h0000;
				hit = slot[4];
			end
		endcase
		if (psel && penable && !q.pready)
		begin
			d.pready = 1'b1;
			d.pslverr = !hit;
			d.prdata = {16'h0000, rdata};
		end

		// Register writes take effect on the completing edge only
		wnew = pwdata[9:0];
		wnew[CTL_SOFT_RESET] = pwdata[CTL_SOFT_RESET] | q.ctl[CTL_SOFT_RESET];
		rise = wnew & ~q.ctl;
		fall = ~wnew & q.ctl;
		if (xfer)
		begin
			d.pready = 1'b0;
			d.pslverr = 1'b0;
			if (pwrite)
				case (paddr[31:2])
					IDX_CONTROL[29:0]:
					begin
						d.ctl = wnew;
						if (rise[CTL_SOFT_RESET])
						begin
							d.seq = st_disable;
							d.rst_cnt = 3'h0;
						end
						else if (rise[CTL_POWER] && q.seq == st_disable)
							d.seq = st_standby;
						else if (fall[CTL_POWER] && q.seq == st_standby)
							d.seq = st_disable;
						else if (rise[CTL_SEQ_EN] && q.seq == st_standby)
						begin
							if (wnew[CTL_MODE_LSB +: 2] == MODE_COORD)
								d.seq = st_wait;
							else if (wnew[CTL_MODE_LSB +: 2] == MODE_CMD)
								d.seq = st_cmd;
						end
						else if (fall[CTL_SEQ_EN] && !(q.seq inside {st_disable, st_standby}))
							d.seq = st_standby;
						else if (rise[CTL_SCAN_START] && q.seq == st_standby)
							d.seq = st_coord;
						else if (rise[CTL_SCAN_STOP] && q.seq inside {st_interval, st_port, st_cmd})
							d.seq = st_standby;
						else if (rise[CTL_AUTO_START] && q.seq == st_wait && q.sync2)
							d.seq = st_coord;
					end
					IDX_IRQ_CAUSE[29:0]:   clr = pwdata[15:0];
					IDX_IRQ_MASK[29:0]:    d.mask = pwdata[15:0];
					IDX_INTERVAL[29:0]:    d.interval = pwdata[15:0];
					IDX_START_DELAY[29:0]: d.delay = pwdata[15:0];
					IDX_ADC_COMMAND[29:0]: d.command = pwdata[15:0];
					IDX_PSCAN_CTL[29:0]:
					begin
						d.pscan_ctl = pwdata[15:0];
						if (pwdata[PSCAN_START] && q.seq == st_standby)
							d.seq = st_port;
					end
					default: ;
				endcase
		end

		// Soft reset holds the sequencer disabled until the bit drops
		if (q.ctl[CTL_SOFT_RESET])
		begin
			d.seq = st_disable;
			if (tick)
			begin
				if (q.rst_cnt == SOFT_RESET_TICKS - 3'h1)
				begin
					d.ctl[CTL_SOFT_RESET] = 1'b0;
					d.rst_cnt = 3'h0;
				end
				else
					d.rst_cnt = q.rst_cnt + 3'h1;
			end
		end

		// New events win over a clear in the same cycle
		d.irq = (q.irq & ~clr) | set;
		d.irq_out = |(q.irq & q.mask);
		d.contact = q.irq[IRQ_PEN] ? q.contact : q.sync2;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			q <= '0;
			q.seq <= st_disable;
			q.ctl <= CTL_RESET;
		end
		else
			q <= d;
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign adc_req = q.adc;
	assign irq = q.irq_out;

	a_reserved_zero: assert property (@(posedge clk) disable iff (!rstn)
		(xfer && !pwrite && paddr[31:2] == IDX_CONTROL[29:0]) |-> prdata[15:14] == 2'b00)
		else $error("reserved control bits not zero");

	a_state_onehot: assert property (@(posedge clk) disable iff (!rstn)
		$onehot(q.seq) && state_code(q.seq) != 3'h3)
		else $error("sequencer state illegal");

	a_soft_reset_end: assert property (@(posedge clk) disable iff (!rstn)
		(q.ctl[CTL_SOFT_RESET] && tick && q.rst_cnt == 3'h3) |=> !q.ctl[CTL_SOFT_RESET] && q.seq == st_disable)
		else $error("soft reset did not end after four ticks");

	a_contact_frozen: assert property (@(posedge clk) disable iff (!rstn)
		(q.irq[IRQ_PEN] ##1 q.irq[IRQ_PEN]) |-> $stable(q.contact))
		else $error("captured contact moved while flag set");

	a_contact_live: assert property (@(posedge clk) disable iff (!rstn)
		!q.irq[IRQ_PEN] |=> q.contact == $past(q.sync2))
		else $error("captured contact not refreshed");

	a_release_stop: assert property (@(posedge clk) disable iff (!rstn)
		(q.seq == st_interval && q.live && !q.sync2 && q.ctl[CTL_AUTO_STOP] && !xfer && !q.ctl[CTL_SOFT_RESET])
		|=> q.seq == st_wait)
		else $error("release with auto-stop did not wait for touch");

	a_mode_select: assert property (@(posedge clk) disable iff (!rstn)
		(xfer && pwrite && paddr[31:2] == IDX_CONTROL[29:0] && q.seq == st_standby && !q.ctl[CTL_SEQ_EN]
		&& pwdata[CTL_SEQ_EN] && !pwdata[CTL_SOFT_RESET] && !q.ctl[CTL_SOFT_RESET] && pwdata[CTL_POWER])
		|=> q.seq == ($past(pwdata[4:3]) == MODE_COORD ? st_wait : $past(pwdata[4:3]) == MODE_CMD ? st_cmd : st_standby))
		else $error("mode field decoded wrongly");

	a_period_ro: assert property (@(posedge clk) disable iff (!rstn)
		$changed(q.period) |-> ($past(tick) || q.period == 16'h0000))
		else $error("period counter changed without a tick");

	a_irq_mask: assert property (@(posedge clk) disable iff (!rstn)
		##1 irq == |($past(q.irq) & $past(q.mask)))
		else $error("interrupt output disagrees with masked causes");

endmodule // touch_panel_scan_control

// ---- core/touch_panel_pkg.sv ----
package touch_panel_pkg;

	// Register indices; byte address on the bus is four times the index
	localparam logic [31:0] IDX_IRQ_PENDING = 32'h0B00_0082;
	localparam logic [31:0] IDX_IRQ_MASK    = 32'h0B00_008E;
	localparam logic [31:0] IDX_CONTROL     = 32'h0B00_0122;
	localparam logic [31:0] IDX_IRQ_CAUSE   = 32'h0B00_0124;
	localparam logic [31:0] IDX_INTERVAL    = 32'h0B00_0126;
	localparam logic [31:0] IDX_START_DELAY = 32'h0B00_0128;
	localparam logic [31:0] IDX_ADC_COMMAND = 32'h0B00_012A;
	localparam logic [31:0] IDX_PSCAN_CTL   = 32'h0B00_0130;
	localparam logic [31:0] IDX_PSCAN_MASK  = 32'h0B00_0132;
	localparam logic [31:0] IDX_PERIOD      = 32'h0B00_013E;

	// Buffer slot order: page 0 buf 0..4, page 1 buf 0..4, port scan buf 0..3
	localparam int BUF_WORDS     = 14;
	localparam int BUFS_PER_PAGE = 5;
	localparam int PORT_BASE     = 10;
	localparam logic [31:0] BUF_IDX [BUF_WORDS] = '{
		32'h0B00_02A0, 32'h0B00_02A2, 32'h0B00_02A4, 32'h0B00_02A6, 32'h0B00_02BC,
		32'h0B00_02A8, 32'h0B00_02AA, 32'h0B00_02AC, 32'h0B00_02AE, 32'h0B00_02BE,
		32'h0B00_02B0, 32'h0B00_02B2, 32'h0B00_02B4, 32'h0B00_02B6};

	// Control register fields
	localparam int CTL_SOFT_RESET = 0;
	localparam int CTL_POWER      = 1;
	localparam int CTL_SEQ_EN     = 2;
	localparam int CTL_MODE_LSB   = 3;
	localparam int CTL_PRESSURE   = 5;
	localparam int CTL_SCAN_START = 6;
	localparam int CTL_SCAN_STOP  = 7;
	localparam int CTL_AUTO_START = 8;
	localparam int CTL_AUTO_STOP  = 9;
	localparam logic [9:0] CTL_RESET = 10'h000;
	localparam logic [1:0] MODE_COORD = 2'h0;
	localparam logic [1:0] MODE_CMD   = 2'h1;
	localparam int PSCAN_START = 0;

	// Sequencer state codes as software reads them
	localparam logic [2:0] STC_DISABLE  = 3'h0;
	localparam logic [2:0] STC_STANDBY  = 3'h1;
	localparam logic [2:0] STC_PORT     = 3'h2;
	localparam logic [2:0] STC_WAIT     = 3'h4;
	localparam logic [2:0] STC_COORD    = 3'h5;
	localparam logic [2:0] STC_INTERVAL = 3'h6;
	localparam logic [2:0] STC_CMD      = 3'h7;

	// Interrupt cause bits
	localparam int IRQ_PEN   = 0;
	localparam int IRQ_PORT  = 1;
	localparam int IRQ_COORD = 2;
	localparam int IRQ_LOST  = 3;
	localparam int IRQ_CMD   = 4;

	localparam logic [2:0] SOFT_RESET_TICKS = 3'h4;
	localparam int TOUCH_DIV_DEFAULT = 16;
	localparam logic [3:0] PORT_CHAN_BASE = 4'h8;

	typedef enum logic [6:0] {
		st_disable  = 7'h01,
		st_standby  = 7'h02,
		st_port     = 7'h04,
		st_wait     = 7'h08,
		st_coord    = 7'h10,
		st_interval = 7'h20,
		st_cmd      = 7'h40
	} seq_t;

	typedef struct packed {
		logic       start;
		logic [3:0] channel;
	} adc_req_t;

endpackage

// ---- core/touch_tick_gen.sv ----
`timescale 1ns/1ps
module touch_tick_gen
	import touch_panel_pkg::*;
#(
	parameter int DIV = TOUCH_DIV_DEFAULT
)(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Touch clock enable, one cycle every DIV cycles
	output logic      tick
);

	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} tick_st_t;

	tick_st_t q;
	tick_st_t d;

	always_comb
	begin
		d = q;
		d.tick = 1'b0;
		if (q.cnt == 16'(DIV - 1))
		begin
			d.cnt  = 16'h0000;
			d.tick = 1'b1;
		end
		else
			d.cnt = q.cnt + 16'h0001;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			q <= '0;
		else
			q <= d;
	end

	assign tick = q.tick;

endmodule // touch_tick_gen

// ---- core/sample_buffer_mem.sv ----
`timescale 1ns/1ps
module sample_buffer_mem
	import touch_panel_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = BUF_WORDS
)(
	// Clock
	input  wire logic                     clk,
	// Write port
	input  wire logic                     we,
	input  wire logic [$clog2(DEPTH)-1:0] waddr,
	input  wire logic [WIDTH-1:0]         wdata,
	// Read port, data one cycle after the address
	input  wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic      [WIDTH-1:0]         rdata
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
		rdata <= mem[raddr];
	end

endmodule // sample_buffer_mem

// ---- bench/adc_panel_model.sv ----
`timescale 1ns/1ps
module adc_panel_model
	import touch_panel_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Converter side of the block
	input  wire adc_req_t   adc_req,
	output logic            adc_done,
	output logic [9:0]      adc_data
);
	logic [3:0] ch_q;
	logic [2:0] cnt_q;
	logic       busy_q;
	logic       slow_q;

	// Result pattern carries the channel so a misrouted store is visible
	always @(posedge clk)
	begin
		adc_done <= 1'b0;
		// Data is only valid with done; toggle it otherwise so stale values never match
		adc_data <= ~adc_data;
		if (!rstn)
		begin
			busy_q   <= 1'b0;
			slow_q   <= 1'b0;
			cnt_q    <= 3'h0;
			ch_q     <= 4'h0;
			adc_data <= 10'h000;
		end
		else if (adc_req.start)
		begin
			ch_q   <= adc_req.channel;
			busy_q <= 1'b1;
			slow_q <= ~slow_q;
			// Alternate prompt and slow conversions
			cnt_q  <= slow_q ? 3'h6 : 3'h1;
		end
		else if (busy_q)
		begin
			if (cnt_q == 3'h1)
			begin
				adc_done <= 1'b1;
				adc_data <= {ch_q, 6'h2A};
				busy_q   <= 1'b0;
			end
			cnt_q <= cnt_q - 3'h1;
		end
	end

endmodule // adc_panel_model

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
	import touch_panel_pkg::*;
;
	logic        clk;
	logic        rstn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pen_contact;
	adc_req_t    adc_req;
	logic        adc_done;
	logic [9:0]  adc_data;
	logic        irq;
	logic [15:0] rv;
	logic        last_err;
	int          n_fail;
	int          samples_checked;

	touch_panel_scan_control #(.TOUCH_DIV(4)) u_touch_panel_scan_control (.clk(clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pen_contact(pen_contact), .adc_req(adc_req), .adc_done(adc_done),
		.adc_data(adc_data), .irq(irq));
	adc_panel_model u_adc_panel_model (.clk(clk), .rstn(rstn), .adc_req(adc_req), .adc_done(adc_done),
		.adc_data(adc_data));

	always #10 clk = ~clk;

	function automatic logic [15:0] exp_conv(input logic [3:0] ch);
		return {6'h00, ch, 6'h2A};
	endfunction

	task automatic tally_and_finish;
		if (n_fail == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Called just after a rising edge; returns one edge after release
	task automatic apb(input logic wr, input logic [31:0] idx, input logic [15:0] wd);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx[29:0], 2'b00};
		pwdata  <= {16'h0000, wd};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			chk("pready", 16'h0001, 16'h0000);
		rv       = prdata[15:0];
		last_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd_chk(input string nm, input logic [31:0] idx, input logic [15:0] e);
		apb(1'b0, idx, 16'h0000);
		chk(nm, e, rv);
		chk("read error", 16'h0000, {15'h0000, last_err});
	endtask

	task automatic poll(input logic [31:0] idx, input logic [15:0] m, input logic [15:0] v);
		int k;
		k = 0;
		do
		begin
			apb(1'b0, idx, 16'h0000);
			k++;
		end
		while ((rv & m) !== v && k < 200);
		chk("polled field", v, rv & m);
	endtask

	task automatic do_reset;
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
	endtask

	initial
	begin
		#(30000 * 20);
		n_fail++;
		tally_and_finish();
	end

	initial
	begin
		logic [31:0] rw_idx [3];
		rw_idx = '{IDX_INTERVAL, IDX_START_DELAY, IDX_IRQ_MASK};
		clk = 1'b0;
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0000_0000;
		pwdata = 32'h0000_0000;
		pen_contact = 1'b0;
		n_fail = 0;
		samples_checked = 0;
		do_reset();
		rd_chk("control", IDX_CONTROL, 16'h0000);
		apb(1'b1, IDX_PERIOD, 16'h5A5A);
		rd_chk("period count", IDX_PERIOD, 16'h0000);
		apb(1'b1, 32'h0B00_0300, 16'h1234);
		chk("unmapped error", 16'h0001, {15'h0000, last_err});
		for (int i = 0; i < BUF_WORDS; i++)
			apb(1'b1, BUF_IDX[i], 16'hA500 + 16'(i));
		for (int i = 0; i < BUF_WORDS; i++)
			rd_chk("buffer", BUF_IDX[i], 16'hA500 + 16'(i));
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b1, rw_idx[i], 16'h0013);
			rd_chk("setting", rw_idx[i], 16'h0013);
		end
		apb(1'b1, IDX_IRQ_MASK, 16'h0000);
		// Power up to standby; upper control bits must not stick
		apb(1'b1, IDX_CONTROL, 16'h0002);
		rd_chk("control standby", IDX_CONTROL, 16'h0402);
		apb(1'b1, IDX_CONTROL, 16'hFC02);
		rd_chk("control ro bits", IDX_CONTROL, 16'h0402);
		// Port scan fills the four port buffers
		apb(1'b1, IDX_PSCAN_CTL, 16'h0001);
		poll(IDX_IRQ_PENDING, 16'h0002, 16'h0002);
		for (int i = 0; i < 4; i++)
			rd_chk("port buffer", BUF_IDX[PORT_BASE + i], exp_conv(PORT_CHAN_BASE + 4'(i)));
		apb(1'b1, IDX_IRQ_CAUSE, 16'h0002);
		poll(IDX_IRQ_PENDING, 16'h0002, 16'h0000);
		// Coordinate mode, enable sequencer: wait for touch
		apb(1'b1, IDX_CONTROL, 16'h0206);
		rd_chk("control waiting", IDX_CONTROL, 16'h1206);
		apb(1'b1, IDX_IRQ_MASK, 16'h0001);
		pen_contact <= 1'b1;
		repeat (10) @(posedge clk);
		poll(IDX_IRQ_PENDING, 16'h0001, 16'h0001);
		chk("irq", 16'h0001, {15'h0000, irq});
		poll(IDX_CONTROL, 16'h2000, 16'h2000);
		pen_contact <= 1'b0;
		repeat (10) @(posedge clk);
		poll(IDX_CONTROL, 16'h2000, 16'h2000);
		apb(1'b1, IDX_IRQ_CAUSE, 16'h0001);
		repeat (10) @(posedge clk);
		poll(IDX_CONTROL, 16'h2000, 16'h0000);
		chk("irq", 16'h0000, {15'h0000, irq});
		// Auto start enabled while touched, one coordinate set, release ends in waiting
		pen_contact <= 1'b1;
		repeat (10) @(posedge clk);
		apb(1'b1, IDX_IRQ_CAUSE, 16'h0001);
		apb(1'b1, IDX_INTERVAL, 16'h0028);
		apb(1'b1, IDX_START_DELAY, 16'h0001);
		apb(1'b1, IDX_CONTROL, 16'h0306);
		// Counter counts up from zero through the set; a landed write would push it past the interval
		apb(1'b1, IDX_PERIOD, 16'h5A5A);
		apb(1'b0, IDX_PERIOD, 16'h0000);
		chk("period bound", 16'h0001, {15'h0000, rv <= 16'h0028});
		poll(IDX_CONTROL, 16'h1C00, 16'h1800);
		for (int i = 0; i < 4; i++)
			rd_chk("page0 buffer", BUF_IDX[i], exp_conv(4'(i)));
		pen_contact <= 1'b0;
		poll(IDX_CONTROL, 16'h1C00, 16'h1000);
		// Soft reset: disable at once, bit self-clears later
		apb(1'b1, IDX_CONTROL, 16'h0307);
		poll(IDX_CONTROL, 16'h1C01, 16'h0001);
		poll(IDX_CONTROL, 16'h1C01, 16'h0000);
		// Second reset while the sequencer sits disabled, then a command conversion
		do_reset();
		rd_chk("control", IDX_CONTROL, 16'h0000);
		apb(1'b1, IDX_CONTROL, 16'h0002);
		apb(1'b1, IDX_CONTROL, 16'h0016);
		rd_chk("reserved mode", IDX_CONTROL, 16'h0416);
		apb(1'b1, IDX_ADC_COMMAND, 16'h0003);
		apb(1'b1, IDX_CONTROL, 16'h000A);
		apb(1'b1, IDX_CONTROL, 16'h000E);
		poll(IDX_IRQ_PENDING, 16'h0010, 16'h0010);
		rd_chk("command result", BUF_IDX[PORT_BASE], exp_conv(4'h3));
		tally_and_finish();
	end
endmodule // tb_top
